/* hdl/stm_defines.svh */
`ifndef STM_DEFINES_SVH
`define STM_DEFINES_SVH

// ==========================================================================
// Widths
`define STM_SPI_W 8
`define STM_WCNT_W 4
`define STM_ID_W 29
`define STM_STD_ID_W 11
`define STM_DATA_W 64
`define STM_LEN_W 4
`define STM_CH_N 16
`define STM_DUR_W 32
`define STM_CFG_W 14

// ==========================================================================
// Reset values
`define STM_CNT_RST 4'h0
`define STM_CH_RST 16'h0000
`define STM_CFG_RST 14'h0000
`define STM_DUR_RST 32'h0000_0000

// ==========================================================================
// Timing: sample clock and duration limits
`define STM_CLK_PERIOD_PS 64'd4000
`define STM_DUR_MIN_PS 64'd10000
`define STM_DUR_MAX_NS 64'd9990000000
`define STM_DUR_MIN_CYC \
  ((`STM_DUR_MIN_PS + `STM_CLK_PERIOD_PS - 64'd1) / `STM_CLK_PERIOD_PS)
`define STM_DUR_MAX_CYC ((`STM_DUR_MAX_NS * 64'd1000) / `STM_CLK_PERIOD_PS)
`define STM_DUR_TOL_DIV 32'h0000_0014

`endif

/* hdl/stm_pkg.sv */
`include "stm_defines.svh"

package stm_pkg;

  // ========================================================================
  // Configuration encodings
  typedef enum logic [2:0] {
    STM_BUS_SPI = 3'h0, STM_BUS_CAN = 3'h1, STM_BUS_LIN = 3'h2,
    STM_BUS_PAR = 3'h3, STM_BUS_LOGIC = 3'h4
  } stm_bus_t;

  typedef enum logic [1:0] {
    STM_SPI_SS = 2'h0, STM_SPI_MOSI = 2'h1, STM_SPI_MISO = 2'h2, STM_SPI_BOTH = 2'h3
  } stm_spi_on_t;

  typedef enum logic [2:0] {
    STM_CAN_SOF = 3'h0, STM_CAN_FTYPE = 3'h1, STM_CAN_ID = 3'h2, STM_CAN_DATA = 3'h3,
    STM_CAN_IDDATA = 3'h4, STM_CAN_EOF = 3'h5, STM_CAN_NOACK = 3'h6, STM_CAN_STUFF = 3'h7
  } stm_can_on_t;

  typedef enum logic [2:0] {
    STM_LIN_SYNC = 3'h0, STM_LIN_ID = 3'h1, STM_LIN_DATA = 3'h2, STM_LIN_IDDATA = 3'h3,
    STM_LIN_WAKE = 3'h4, STM_LIN_SLEEP = 3'h5, STM_LIN_ERR = 3'h6
  } stm_lin_on_t;

  typedef enum logic [1:0] {
    STM_FRM_DATA = 2'h0, STM_FRM_REMOTE = 2'h1, STM_FRM_ERROR = 2'h2, STM_FRM_OVLD = 2'h3
  } stm_frm_t;

  typedef enum logic [1:0] {
    STM_DIR_WRITE = 2'h0, STM_DIR_READ = 2'h1, STM_DIR_ANY = 2'h2
  } stm_dir_t;

  typedef enum logic [2:0] {
    STM_REL_EQ = 3'h0, STM_REL_NE = 3'h1, STM_REL_LT = 3'h2,
    STM_REL_GT = 3'h3, STM_REL_LE = 3'h4, STM_REL_GE = 3'h5
  } stm_rel_t;

  typedef enum logic [1:0] {
    STM_CH_X = 2'h0, STM_CH_LOW = 2'h1, STM_CH_HIGH = 2'h2, STM_CH_CLK = 2'h3
  } stm_ch_t;

  typedef enum logic [1:0] {
    STM_EDGE_RISE = 2'h0, STM_EDGE_FALL = 2'h1, STM_EDGE_ANY = 2'h2
  } stm_edge_t;

  typedef enum logic [2:0] {
    STM_WHEN_TRUE = 3'h0, STM_WHEN_FALSE = 3'h1, STM_WHEN_GT = 3'h2,
    STM_WHEN_LT = 3'h3, STM_WHEN_EQ = 3'h4, STM_WHEN_NE = 3'h5
  } stm_when_t;

  // ========================================================================
  // Module state
  typedef struct packed {
    logic trig;
    logic [`STM_WCNT_W-1:0] spi_cnt;
    logic id_hit;
    logic [`STM_CH_N-1:0] ch_prev;
    logic pat_prev;
    logic [`STM_CFG_W-1:0] cfg_prev;
  } stm_top_st_t;

  typedef struct packed {
    logic [`STM_DUR_W-1:0] cnt;
    logic pat_prev;
    logic fire;
  } stm_dur_st_t;

endpackage

/* hdl/stm_dur_if.sv */
`timescale 1ns/100ps
`include "stm_defines.svh"

// ==========================================================================
// Link between the matcher and its duration qualifier
interface stm_dur_if;
  logic pat;
  logic clr;
  logic [1:0] mode;
  logic [`STM_DUR_W-1:0] dur;
  logic fire;
  modport ctl (output pat, output clr, output mode, output dur, input fire);
  modport qual (input pat, input clr, input mode, input dur, output fire);
endinterface

/* hdl/stm_sync.sv */
`timescale 1ns/100ps

// ==========================================================================
// Two-stage synchroniser; only the second stage is visible
module stm_sync #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } stm_sync_st_t;

  stm_sync_st_t st;
  stm_sync_st_t next_st;

  // Shift the pins through both stages
  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;
endmodule // stm_sync

/* hdl/stm_dur.sv */
`timescale 1ns/100ps
`include "stm_defines.svh"

// ==========================================================================
// Duration qualifier: times each true interval of the pattern
module stm_dur #(
  parameter logic [`STM_DUR_W-1:0] DUR_MAX_CYC = `STM_DUR_W'(`STM_DUR_MAX_CYC)
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  stm_dur_if.qual dif
);
  localparam logic [`STM_DUR_W-1:0] MIN_CYC = `STM_DUR_W'(`STM_DUR_MIN_CYC);
  localparam logic [`STM_DUR_W-1:0] SAT = '1;

  stm_pkg::stm_dur_st_t st;
  stm_pkg::stm_dur_st_t next_st;
  logic [`STM_DUR_W-1:0] lim;
  logic [`STM_DUR_W-1:0] tol;
  logic [`STM_DUR_W-1:0] diff;
  logic near;

  // Clamp the programmed time into its legal range, derive the 5% window
  always_comb begin
    lim = (dif.dur < MIN_CYC) ? MIN_CYC : ((dif.dur > DUR_MAX_CYC) ? DUR_MAX_CYC : dif.dur);
    tol = lim / `STM_DUR_TOL_DIV;
    diff = (st.cnt > lim) ? (st.cnt - lim) : (lim - st.cnt);
    near = (diff <= tol);
  end

  // Count while true; judge the interval on the falling edge only
  always_comb begin
    next_st = st;
    next_st.fire = 1'b0;
    next_st.pat_prev = dif.pat;
    if (dif.clr) begin
      next_st = '0;
    end else begin
      if (dif.pat && !st.pat_prev) begin
        next_st.cnt = `STM_DUR_W'(1);
      end else if (dif.pat && (st.cnt != SAT)) begin
        next_st.cnt = st.cnt + `STM_DUR_W'(1);
      end
      if (!dif.pat && st.pat_prev) begin
        unique case (dif.mode)
          2'h0: next_st.fire = (st.cnt > lim);
          2'h1: next_st.fire = (st.cnt < lim);
          2'h2: next_st.fire = near;
          2'h3: next_st.fire = !near;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dif.fire = st.fire;

  // Counter holds at its ceiling while the pattern stays true
  cnt_sat_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (st.cnt == SAT && dif.pat && st.pat_prev && !dif.clr) |=> (st.cnt == SAT))
    else $error("duration counter left saturation");

  // A long interval in greater-than mode fires on the next edge
  dur_gt_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!dif.clr && !dif.pat && st.pat_prev && dif.mode == 2'h0 && st.cnt > lim)
    |=> dif.fire)
    else $error("greater-than interval did not fire");
endmodule // stm_dur

/* hdl/stm_trigger.sv */
`timescale 1ns/100ps
`include "stm_defines.svh"

// Behaviour
// - SPI fires on select, MOSI, MISO or both
// - SPI needs N consecutive matching words
// - Pattern digits are zero, one or don't-care
// - CAN offers eight selectable frame events
// - CAN frame-type event picks one of four
// - CAN identifier compared in chosen format
// - CAN identifier qualified by frame direction
// - Data compare uses one to eight bytes
// - LIN offers seven selectable frame events
// - Data relation: equal, unequal, less, greater, etc
// - Parallel bus fires on masked word match
// - Channels high, low, don't-care or clock
// - Clocked pattern sampled on chosen edge
// - Unclocked pattern fires going true or false
// - Fire on longer or shorter true interval
// - Equal duration means within five percent
module stm_trigger #(
  parameter logic [`STM_DUR_W-1:0] DUR_MAX_CYC = `STM_DUR_W'(`STM_DUR_MAX_CYC)
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Mode selection
  input wire logic [2:0] BUS_TYPE_I,
  input wire logic [1:0] SPI_ON_I,
  input wire logic [2:0] CAN_ON_I,
  input wire logic [2:0] LIN_ON_I,
  // SPI configuration and decoded traffic
  input wire logic [`STM_WCNT_W-1:0] SPI_WORDS_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MOSI_PAT_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MOSI_CARE_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MISO_PAT_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MISO_CARE_I,
  input wire logic SPI_SS_START_I,
  input wire logic SPI_WORD_VLD_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MOSI_I,
  input wire logic [`STM_SPI_W-1:0] SPI_MISO_I,
  // CAN / LIN configuration
  input wire logic [1:0] FRM_KIND_SEL_I,
  input wire logic ID_EXT_SEL_I,
  input wire logic [1:0] ID_DIR_SEL_I,
  input wire logic [`STM_ID_W-1:0] ID_PAT_I,
  input wire logic [`STM_ID_W-1:0] ID_CARE_I,
  input wire logic [`STM_LEN_W-1:0] DATA_LEN_I,
  input wire logic [`STM_DATA_W-1:0] DATA_PAT_I,
  input wire logic [`STM_DATA_W-1:0] DATA_CARE_I,
  input wire logic [2:0] DATA_REL_I,
  // CAN / LIN decoded frame events
  input wire logic FRM_SOF_I,
  input wire logic FRM_EOF_I,
  input wire logic FRM_KIND_VLD_I,
  input wire logic [1:0] FRM_KIND_I,
  input wire logic FRM_ID_VLD_I,
  input wire logic [`STM_ID_W-1:0] FRM_ID_I,
  input wire logic FRM_ID_EXT_I,
  input wire logic FRM_READ_I,
  input wire logic FRM_DATA_VLD_I,
  input wire logic [`STM_DATA_W-1:0] FRM_DATA_I,
  input wire logic [`STM_LEN_W-1:0] FRM_LEN_I,
  input wire logic FRM_NOACK_I,
  input wire logic FRM_STUFF_ERR_I,
  input wire logic LIN_SYNC_I,
  input wire logic LIN_WAKE_I,
  input wire logic LIN_SLEEP_I,
  input wire logic LIN_ERR_I,
  // Parallel bus
  input wire logic [`STM_CH_N-1:0] PAR_PINS_I,
  input wire logic [`STM_CH_N-1:0] PAR_PAT_I,
  input wire logic [`STM_CH_N-1:0] PAR_CARE_I,
  // Logic channels
  input wire logic [`STM_CH_N-1:0] CH_PINS_I,
  input wire logic [2*`STM_CH_N-1:0] CH_CFG_I,
  input wire logic [1:0] CLK_EDGE_I,
  input wire logic [2:0] LOGIC_WHEN_I,
  input wire logic [`STM_DUR_W-1:0] DUR_CYC_I,
  // Results
  output logic TRIG_O,
  output logic [`STM_WCNT_W-1:0] SPI_MATCH_CNT_O
);

  // ========================================================================
  // Signals
  stm_pkg::stm_top_st_t st;
  stm_pkg::stm_top_st_t next_st;
  logic [`STM_CH_N-1:0] ch;
  logic [`STM_CH_N-1:0] par;
  logic [`STM_CFG_W-1:0] cfg;
  logic cfg_chg;
  logic mosi_hit;
  logic miso_hit;
  logic spi_hit;
  logic [`STM_WCNT_W-1:0] spi_need;
  logic id_ok;
  logic data_ok;
  logic par_hit;
  logic [`STM_CH_N-1:0] ch_ok;
  logic [`STM_CH_N-1:0] clk_ch;
  logic pat;
  logic clk_edge;
  logic fire;
  stm_dur_if dif();

  // ========================================================================
  // Pin synchronisers (channels and parallel bus both come from pins)
  stm_sync #(.W(`STM_CH_N)) u_ch_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(CH_PINS_I),
    .q_o(ch)
  );

  stm_sync #(.W(`STM_CH_N)) u_par_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .d_i(PAR_PINS_I),
    .q_o(par)
  );

  // ========================================================================
  // Helper: relation between masked, length-limited received and set data
  function automatic logic data_rel(input logic [`STM_DATA_W-1:0] rx,
                                    input logic [`STM_LEN_W-1:0] rx_len);
    logic [`STM_LEN_W-1:0] len;
    logic [`STM_DATA_W-1:0] keep;
    logic [`STM_DATA_W-1:0] a;
    logic [`STM_DATA_W-1:0] b;
    logic r;
    len = (DATA_LEN_I == 4'h0) ? 4'h1 : ((DATA_LEN_I > 4'h8) ? 4'h8 : DATA_LEN_I);
    keep = {`STM_DATA_W{1'b1}} << (7'(4'h8 - len) * 7'h08);
    a = rx & keep & DATA_CARE_I;
    b = DATA_PAT_I & keep & DATA_CARE_I;
    unique case (stm_pkg::stm_rel_t'(DATA_REL_I))
      stm_pkg::STM_REL_EQ: r = (a == b);
      stm_pkg::STM_REL_NE: r = (a != b);
      stm_pkg::STM_REL_LT: r = (a < b);
      stm_pkg::STM_REL_GT: r = (a > b);
      stm_pkg::STM_REL_LE: r = (a <= b);
      stm_pkg::STM_REL_GE: r = (a >= b);
      default: r = 1'b0;
    endcase
    return r && (rx_len >= len);
  endfunction

  // ========================================================================
  // Configuration watch: any change of bus type or mode selection drops partial progress
  assign cfg = {BUS_TYPE_I, SPI_ON_I, CAN_ON_I, LIN_ON_I, LOGIC_WHEN_I};
  assign cfg_chg = (cfg != st.cfg_prev);

  // SPI word comparison per line, don't-care bits excluded
  always_comb begin
    mosi_hit = ((SPI_MOSI_I ^ SPI_MOSI_PAT_I) & SPI_MOSI_CARE_I) == '0;
    miso_hit = ((SPI_MISO_I ^ SPI_MISO_PAT_I) & SPI_MISO_CARE_I) == '0;
    unique case (stm_pkg::stm_spi_on_t'(SPI_ON_I))
      stm_pkg::STM_SPI_MOSI: spi_hit = mosi_hit;
      stm_pkg::STM_SPI_MISO: spi_hit = miso_hit;
      stm_pkg::STM_SPI_BOTH: spi_hit = mosi_hit && miso_hit;
      stm_pkg::STM_SPI_SS: spi_hit = 1'b0;
    endcase
    spi_need = (SPI_WORDS_I == '0) ? `STM_WCNT_W'(1) : SPI_WORDS_I;
  end

  // Frame identifier and data qualification
  always_comb begin
    id_ok = ((FRM_ID_I ^ ID_PAT_I) & ID_CARE_I) == '0;
    if (stm_pkg::stm_bus_t'(BUS_TYPE_I) == stm_pkg::STM_BUS_CAN) begin
      // Standard ids only look at the low bits of the pattern
      if (!ID_EXT_SEL_I) begin
        id_ok = (((FRM_ID_I ^ ID_PAT_I) & ID_CARE_I) & `STM_ID_W'(12'h7FF)) == '0;
      end
      id_ok = id_ok && (FRM_ID_EXT_I == ID_EXT_SEL_I);
      unique case (stm_pkg::stm_dir_t'(ID_DIR_SEL_I))
        stm_pkg::STM_DIR_WRITE: id_ok = id_ok && !FRM_READ_I;
        stm_pkg::STM_DIR_READ: id_ok = id_ok && FRM_READ_I;
        default: id_ok = id_ok;
      endcase
    end
    data_ok = data_rel(FRM_DATA_I, FRM_LEN_I);
  end

  // Parallel word and logic pattern evaluation
  always_comb begin
    par_hit = ((par ^ PAR_PAT_I) & PAR_CARE_I) == '0;
    for (int i = 0; i < `STM_CH_N; i++) begin
      unique case (stm_pkg::stm_ch_t'(CH_CFG_I[2*i +: 2]))
        stm_pkg::STM_CH_HIGH: ch_ok[i] = ch[i];
        stm_pkg::STM_CH_LOW: ch_ok[i] = !ch[i];
        stm_pkg::STM_CH_X: ch_ok[i] = 1'b1;
        stm_pkg::STM_CH_CLK: ch_ok[i] = 1'b1;
      endcase
      clk_ch[i] = (CH_CFG_I[2*i +: 2] == 2'h3);
    end
    pat = &ch_ok;
    unique case (stm_pkg::stm_edge_t'(CLK_EDGE_I))
      stm_pkg::STM_EDGE_RISE: clk_edge = |(clk_ch & ch & ~st.ch_prev);
      stm_pkg::STM_EDGE_FALL: clk_edge = |(clk_ch & ~ch & st.ch_prev);
      default: clk_edge = |(clk_ch & (ch ^ st.ch_prev));
    endcase
  end

  // ========================================================================
  // Duration qualifier hookup; only timed when-modes without a clock use it
  assign dif.pat = pat;
  assign dif.clr = cfg_chg || (|clk_ch);
  assign dif.mode = 2'(LOGIC_WHEN_I - 3'h2);
  assign dif.dur = DUR_CYC_I;

  stm_dur #(.DUR_MAX_CYC(DUR_MAX_CYC)) u_dur (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .dif(dif)
  );

  // ========================================================================
  // Event selection: only the active bus type and trigger mode may fire
  always_comb begin
    next_st = st;
    next_st.cfg_prev = cfg;
    next_st.ch_prev = ch;
    next_st.pat_prev = pat;
    fire = 1'b0;
    unique case (BUS_TYPE_I)
      3'h0: begin
        if (SPI_ON_I == 2'h0) begin
          fire = SPI_SS_START_I;
        end else if (SPI_SS_START_I) begin
          next_st.spi_cnt = '0;
        end else if (SPI_WORD_VLD_I) begin
          if (!spi_hit) begin
            next_st.spi_cnt = '0;
          end else if (st.spi_cnt + `STM_WCNT_W'(1) >= spi_need) begin
            fire = 1'b1;
            next_st.spi_cnt = '0;
          end else begin
            next_st.spi_cnt = st.spi_cnt + `STM_WCNT_W'(1);
          end
        end
      end
      3'h1: begin
        unique case (stm_pkg::stm_can_on_t'(CAN_ON_I))
          stm_pkg::STM_CAN_SOF: fire = FRM_SOF_I;
          stm_pkg::STM_CAN_FTYPE: fire = FRM_KIND_VLD_I && (FRM_KIND_I == FRM_KIND_SEL_I);
          stm_pkg::STM_CAN_ID: fire = FRM_ID_VLD_I && id_ok;
          stm_pkg::STM_CAN_DATA: fire = FRM_DATA_VLD_I && data_ok;
          stm_pkg::STM_CAN_IDDATA: fire = FRM_DATA_VLD_I && data_ok && st.id_hit;
          stm_pkg::STM_CAN_EOF: fire = FRM_EOF_I;
          stm_pkg::STM_CAN_NOACK: fire = FRM_NOACK_I;
          stm_pkg::STM_CAN_STUFF: fire = FRM_STUFF_ERR_I;
        endcase
      end
      3'h2: begin
        unique case (LIN_ON_I)
          3'h0: fire = LIN_SYNC_I;
          3'h1: fire = FRM_ID_VLD_I && id_ok;
          3'h2: fire = FRM_DATA_VLD_I && data_ok;
          3'h3: fire = FRM_DATA_VLD_I && data_ok && st.id_hit;
          3'h4: fire = LIN_WAKE_I;
          3'h5: fire = LIN_SLEEP_I;
          3'h6: fire = LIN_ERR_I;
          default: fire = 1'b0;
        endcase
      end
      3'h3: fire = par_hit;
      3'h4: begin
        if (|clk_ch) begin
          fire = clk_edge && pat;
        end else if (LOGIC_WHEN_I == 3'h0) begin
          fire = pat && !st.pat_prev;
        end else if (LOGIC_WHEN_I == 3'h1) begin
          fire = !pat && st.pat_prev;
        end else if (LOGIC_WHEN_I <= 3'h5) begin
          fire = dif.fire;
        end
      end
      default: fire = 1'b0;
    endcase
    // Identifier half of an id-plus-data match waits for the data field
    if (FRM_SOF_I) begin
      next_st.id_hit = 1'b0;
    end else if (FRM_ID_VLD_I) begin
      next_st.id_hit = id_ok;
    end
    if (cfg_chg) begin
      next_st.spi_cnt = '0;
      next_st.id_hit = 1'b0;
    end
    next_st.trig = fire;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign TRIG_O = st.trig;
  assign SPI_MATCH_CNT_O = st.spi_cnt;

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence ss_start_s;
    BUS_TYPE_I == 3'h0 && SPI_ON_I == 2'h0 && SPI_SS_START_I;
  endsequence

  sequence trig_pulse_s;
    TRIG_O;
  endsequence

  ss_fire_a: assert property (ss_start_s |=> trig_pulse_s)
    else $error("select start did not trigger");

  spi_miss_a: assert property (BUS_TYPE_I == 3'h0 && SPI_ON_I != 2'h0 && SPI_WORD_VLD_I
    && !spi_hit |=> SPI_MATCH_CNT_O == '0)
    else $error("mismatching word kept spi progress");

  can_sof_a: assert property (BUS_TYPE_I == 3'h1 && CAN_ON_I == 3'h0 && FRM_SOF_I
    |=> TRIG_O)
    else $error("start of frame did not trigger");

  ftype_miss_a: assert property (BUS_TYPE_I == 3'h1 && CAN_ON_I == 3'h1
    && !(FRM_KIND_VLD_I && FRM_KIND_I == FRM_KIND_SEL_I) |=> !TRIG_O)
    else $error("wrong frame kind triggered");

  par_hit_a: assert property (BUS_TYPE_I == 3'h3 && par_hit |=> TRIG_O)
    else $error("parallel match did not trigger");

  clk_gate_a: assert property (BUS_TYPE_I == 3'h4 && (|clk_ch) && !clk_edge
    |=> !TRIG_O)
    else $error("clocked pattern fired without edge");

  goes_true_a: assert property (BUS_TYPE_I == 3'h4 && !(|clk_ch) && LOGIC_WHEN_I == 3'h0
    && pat && !st.pat_prev |=> TRIG_O)
    else $error("pattern going true did not trigger");

  idle_mode_a: assert property (BUS_TYPE_I > 3'h4 |=> !TRIG_O)
    else $error("unselected mode triggered");
endmodule // stm_trigger

/* sim/stm_far_model.sv */
`timescale 1ns/100ps

// ==========================================================================
// Far side: decoded SPI strobes and the pins under observation
module stm_far_model (
  input wire logic clk_i,
  output logic ss_o,
  output logic vld_o,
  output logic [7:0] mosi_o,
  output logic [7:0] miso_o,
  output logic [15:0] par_o,
  output logic [15:0] ch_o
);
  // Idle values at time zero
  initial begin
    {ss_o, vld_o, mosi_o, miso_o, par_o, ch_o} = '0;
  end

  // One word strobe; the data lines then show the inverse, never a held copy
  task automatic word(input logic [7:0] mo, input logic [7:0] mi);
    vld_o = 1'b1;
    mosi_o = mo;
    miso_o = mi;
    @(posedge clk_i);
    #1;
    vld_o = 1'b0;
    mosi_o = ~mo;
    miso_o = ~mi;
  endtask

  // Select goes active for one sample
  task automatic sel();
    ss_o = 1'b1;
    @(posedge clk_i);
    #1;
    ss_o = 1'b0;
  endtask

  // Pins are asynchronous to the matcher
  task automatic par(input logic [15:0] v);
    par_o = v;
  endtask

  task automatic pins(input logic [15:0] v);
    ch_o = v;
  endtask
endmodule // stm_far_model

/* sim/tb.sv */
`timescale 1ns/100ps

// ==========================================================================
// Self-checking bench for the trigger matcher
module tb;
  // Expected trigger per trial: relation table, then duration table
  localparam logic [11:0] REL_EXP = 12'hD89;
  localparam logic [11:0] DUR_EXP = 12'hA8C;
  logic clk, rst_n, ss, w_vld, vld_k, id_vld, ext, rd, d_vld, ext_sel, trig;
  logic [2:0] bus, can_on, lin_on, rel, when;
  logic [1:0] spi_on, k_sel, kind, dir, edge_sel;
  logic [3:0] words, len, rx_len, cnt;
  logic [7:0] ev, mo_p, mo_c, mi_p, mi_c, mosi, miso;
  logic [28:0] id_p, id_c, id;
  logic [63:0] d_p, d_c, d;
  logic [15:0] par, par_p, par_c, ch;
  logic [31:0] cfg, dur;
  int err_count = 0;
  int compares = 0;

  stm_far_model stm_far_model_i (.clk_i(clk), .ss_o(ss), .vld_o(w_vld), .mosi_o(mosi),
    .miso_o(miso), .par_o(par), .ch_o(ch));
  // Short ceiling of 200 cycles on the programmed duration; the counter itself saturates at all ones
  stm_trigger #(.DUR_MAX_CYC(32'h0000_00C8)) stm_trigger_i (.CLK_I(clk), .RST_N_I(rst_n),
    .BUS_TYPE_I(bus), .SPI_ON_I(spi_on), .CAN_ON_I(can_on), .LIN_ON_I(lin_on),
    .SPI_WORDS_I(words), .SPI_MOSI_PAT_I(mo_p), .SPI_MOSI_CARE_I(mo_c),
    .SPI_MISO_PAT_I(mi_p), .SPI_MISO_CARE_I(mi_c), .SPI_SS_START_I(ss),
    .SPI_WORD_VLD_I(w_vld), .SPI_MOSI_I(mosi), .SPI_MISO_I(miso), .FRM_KIND_SEL_I(k_sel),
    .ID_EXT_SEL_I(ext_sel), .ID_DIR_SEL_I(dir), .ID_PAT_I(id_p), .ID_CARE_I(id_c),
    .DATA_LEN_I(len), .DATA_PAT_I(d_p), .DATA_CARE_I(d_c), .DATA_REL_I(rel),
    .FRM_SOF_I(ev[0]), .FRM_EOF_I(ev[1]), .FRM_KIND_VLD_I(vld_k), .FRM_KIND_I(kind),
    .FRM_ID_VLD_I(id_vld), .FRM_ID_I(id), .FRM_ID_EXT_I(ext), .FRM_READ_I(rd),
    .FRM_DATA_VLD_I(d_vld), .FRM_DATA_I(d), .FRM_LEN_I(rx_len), .FRM_NOACK_I(ev[2]),
    .FRM_STUFF_ERR_I(ev[3]), .LIN_SYNC_I(ev[4]), .LIN_WAKE_I(ev[5]),
    .LIN_SLEEP_I(ev[6]), .LIN_ERR_I(ev[7]), .PAR_PINS_I(par), .PAR_PAT_I(par_p),
    .PAR_CARE_I(par_c), .CH_PINS_I(ch), .CH_CFG_I(cfg), .CLK_EDGE_I(edge_sel),
    .LOGIC_WHEN_I(when), .DUR_CYC_I(dur), .TRIG_O(trig), .SPI_MATCH_CNT_O(cnt));

  // ========================================================================
  // Shared helpers: inputs always move 1 ns after the edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ========================================================================
  // Scenarios
  // Words must match two, three or four times in a row per mode; a late MISO miss only spares MOSI mode
  task automatic t_spi();
    bus = stm_pkg::STM_BUS_SPI;
    mo_c = 8'hF0;
    for (int on = 1; on < 4; on++) begin
      spi_on = 2'(on);
      {words, mo_p} = {4'(on + 1), 8'hA5 ^ 8'(on)};
      {mi_p, mi_c} = {8'h3C ^ 8'(on & 2), 8'hFF ^ 8'(on & 2)};
      step(2);
      stm_far_model_i.word(8'hA1, 8'h3C);
      chk(cnt, 4'h1);
      step(1);
      stm_far_model_i.word(8'hA1, 8'h3D);
      chk(4'(trig), 4'(on == 1));
      chk(cnt, 4'h0);
    end
    step(1);
    stm_far_model_i.word(8'hA1, 8'h3C);
    spi_on = stm_pkg::STM_SPI_MOSI;
    step(1);
    chk(cnt, 4'h0);
    spi_on = stm_pkg::STM_SPI_SS;
    step(2);
    stm_far_model_i.sel();
    chk(4'(trig), 4'h1);
    ev = 8'h01;
    step(1);
    ev = 8'h00;
    chk(4'(trig), 4'h0);
  endtask

  // A pulse fires its own mode only, and for one cycle
  task automatic ev_case(input logic [2:0] b, input logic [2:0] m, input int i);
    bus = b;
    can_on = m;
    lin_on = m;
    step(2);
    ev = 8'h01 << i;
    step(1);
    chk(4'(trig), 4'h1);
    ev = 8'h01 << ((i + 1) % 8);
    step(1);
    ev = 8'h00;
    chk(4'(trig), 4'h0);
  endtask

  // Each kind selected, then the right and a wrong kind received
  task automatic t_kind();
    can_on = stm_pkg::STM_CAN_FTYPE;
    for (int k = 0; k < 8; k++) begin
      k_sel = 2'(k / 2);
      kind = 2'(k / 2) ^ 2'(k % 2);
      vld_k = 1'b1;
      step(1);
      chk(4'(trig), 4'(k % 2 == 0));
    end
    vld_k = 1'b0;
  endtask

  // Extended read id, low nibble free, then broken; then standard write and any
  task automatic t_id();
    can_on = stm_pkg::STM_CAN_ID;
    id_c = 29'h1FFF_FFF0;
    step(2);
    for (int k = 0; k < 6; k++) begin
      ext_sel = (k < 4);
      dir = 2'((k < 4) ? 1 : 2 * k - 8);
      id_p = 29'h0ABC_DEF1 | (29'(k / 4) << 24);
      ext = ext_sel ^ (k == 1);
      rd = (k != 2 && k != 4);
      id = (k == 3) ? 29'h0ABC_DEE7 : 29'h0ABC_DEF7;
      id_vld = 1'b1;
      step(1);
      chk(4'(trig), 4'(k == 0 || k > 3));
    end
    id_vld = 1'b0;
  endtask

  // Two bytes compared: equal in them only, or greater
  task automatic t_data();
    can_on = stm_pkg::STM_CAN_DATA;
    {len, d_c} = {4'h2, {64{1'b1}}};
    step(2);
    for (int k = 0; k < 12; k++) begin
      rel = 3'(k / 2);
      {rx_len, d_p} = {4'(8 - k / 4), 64'h1234_0000_0000_0000 | 64'(k)};
      d = (k % 2) ? 64'h1235_0000_0000_0000 : 64'h1234_FFFF_FFFF_FFFF;
      d_vld = 1'b1;
      step(1);
      chk(4'(trig), 4'(REL_EXP[k]));
    end
    d_vld = 1'b0;
  endtask

  // Level output that follows the masked word, three samples late
  task automatic t_par();
    bus = stm_pkg::STM_BUS_PAR;
    {par_p, par_c} = {16'h00A5, 16'h00FF};
    stm_far_model_i.par(16'hFFA5);
    step(2);
    chk(4'(trig), 4'h0);
    step(1);
    chk(4'(trig), 4'h1);
    step(1);
    chk(4'(trig), 4'h1);
    stm_far_model_i.par(16'h00A4);
    par_c = 16'h0FFF;
    step(3);
    chk(4'(trig), 4'h0);
  endtask

  // Channel 0 high, 1 low; later channel 2 clocks on rise, then on fall
  task automatic t_logic();
    bus = stm_pkg::STM_BUS_LOGIC;
    {cfg, dur} = {32'h0000_0006, 32'h0000_0005};
    for (int w = 0; w < 2; w++) begin
      when = 3'(w);
      stm_far_model_i.pins(16'h0000);
      step(4);
      stm_far_model_i.pins(16'hFFF1);
      step(3);
      chk(4'(trig), 4'(w == 0));
      stm_far_model_i.pins(16'h0000);
      step(3);
      chk(4'(trig), 4'(w == 1));
    end
    cfg = 32'h0000_0036;
    for (int e = 0; e < 2; e++) begin
      edge_sel = 2'(e);
      stm_far_model_i.pins(16'h0001);
      step(4);
      stm_far_model_i.pins(16'h0005);
      step(3);
      chk(4'(trig), 4'(e == 0));
      stm_far_model_i.pins(16'h0001);
      step(3);
      chk(4'(trig), 4'(e == 1));
    end
  endtask

  // Intervals of 5, 10, 15 against T = 10 (tolerance rounds to zero)
  task automatic t_dur();
    {cfg, dur} = {32'h0000_0006, 32'h0000_000A};
    for (int k = 0; k < 12; k++) begin
      when = 3'(2 + k / 3);
      stm_far_model_i.pins(16'h0000);
      step(4);
      stm_far_model_i.pins(16'h0001);
      step(5 + 5 * (k % 3));
      stm_far_model_i.pins(16'h0000);
      step(4);
      chk(4'(trig), 4'(DUR_EXP[k]));
    end
  endtask

  // ========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run is well under 2000 cycles
  initial begin
    #20000;
    err_count++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    {bus, spi_on, can_on, lin_on, rel, when, k_sel, kind, dir, edge_sel, ext_sel} = '0;
    {vld_k, id_vld, ext, rd, d_vld, ev, words, len, rx_len} = '0;
    {mo_p, mo_c, mi_p, mi_c, id_p, id_c, id, d_p, d_c, d, par_p, par_c, cfg, dur} = '0;
    step(5);
    rst_n = 1'b1;
    chk(4'(trig), 4'h0);
    t_spi();
    ev_case(stm_pkg::STM_BUS_CAN, stm_pkg::STM_CAN_SOF, 0);
    ev_case(stm_pkg::STM_BUS_CAN, stm_pkg::STM_CAN_EOF, 1);
    ev_case(stm_pkg::STM_BUS_CAN, stm_pkg::STM_CAN_NOACK, 2);
    ev_case(stm_pkg::STM_BUS_CAN, stm_pkg::STM_CAN_STUFF, 3);
    ev_case(stm_pkg::STM_BUS_LIN, stm_pkg::STM_LIN_SYNC, 4);
    ev_case(stm_pkg::STM_BUS_LIN, stm_pkg::STM_LIN_WAKE, 5);
    ev_case(stm_pkg::STM_BUS_LIN, stm_pkg::STM_LIN_SLEEP, 6);
    ev_case(stm_pkg::STM_BUS_LIN, stm_pkg::STM_LIN_ERR, 7);
    bus = stm_pkg::STM_BUS_CAN;
    t_kind();
    t_id();
    t_data();
    t_par();
    t_logic();
    t_dur();
    summarize();
  end
endmodule // tb
